// *** wpom_pkg.sv ***
// constants, types and field layout of the wan path overhead monitor
// How it works
// - transmit path trace octet repeats a message of the selected length from transmit trace registers
// - received trace octets stored in rotation order, no message start search
// - trace length selectable per direction: one octet, 16 octets or 64 octets
// - 64-octet mode uses base words for octets 0-15, extended words for rest
// - receive trace store takes one new octet per frame, no persistence check
// - transmit parity octet is even BIP-8 over previous payload, put in next frame
// - receive BIP-8 compared with next frame parity; legacy counter wraps, reset clears
// - saturating 32-bit parity counter accumulates between ticks, latched then cleared
// - parity block mode adds at most one per errored frame
// - error counts pass to transmit side via one-entry fifo; a newer count replaces an unread one
// - transmit remote error field is zero when fifo holds no count
// - transmitted signal label comes from register resetting to 0x1A
// - label accepted after five equal frames; accepted 0x00 raises unequipped
// - accepted nonzero label unlike expected label sets mismatch status and pending
// - label mismatch changes the enhanced remote defect code sent back
// - fifo count goes in top four bits of each transmitted path status octet while the fifo holds one
// - 16-bit remote error counter counts errored blocks, wraps, clears on reset
// - saturating 32-bit remote error counter per tick period, optional block mode
// - remote error block mode has its own configuration bit
// - pending flag of each error counter but the legacy parity one held while nonzero until read; live bit too
// - each event drives either interrupt output through its own two mask bits
`default_nettype none
package wpom_pkg;
   localparam logic [11:0] WPOM_CTRL_OFS = 12'h000;
   localparam logic [11:0] WPOM_LABEL_OFS = 12'h004;
   localparam logic [11:0] WPOM_STATUS_OFS = 12'h008;
   localparam logic [11:0] WPOM_PEND_OFS = 12'h00C;
   localparam logic [11:0] WPOM_MASKA_OFS = 12'h010;
   localparam logic [11:0] WPOM_MASKB_OFS = 12'h014;
   localparam logic [11:0] WPOM_LPAR_OFS = 12'h018;
   localparam logic [11:0] WPOM_PMPAR_OFS = 12'h01C;
   localparam logic [11:0] WPOM_LREM_OFS = 12'h020;
   localparam logic [11:0] WPOM_PMREM_OFS = 12'h024;
   localparam logic [5:0] WPOM_TXTRACE_BLK = 6'h01;
   localparam logic [5:0] WPOM_RXTRACE_BLK = 6'h02;
   localparam int WPOM_TRACE_WORDS = 16;
   localparam int WPOM_CTRL_TXLEN_LSB = 0;
   localparam int WPOM_CTRL_RXLEN_LSB = 2;
   localparam int WPOM_CTRL_PARBLK_BIT = 4;
   localparam int WPOM_CTRL_REMBLK_BIT = 5;
   localparam logic [5:0] WPOM_CTRL_RST = 6'h05;
   localparam logic [7:0] WPOM_LABEL_RST = 8'h1A;
   localparam logic [7:0] WPOM_UNEQ_LABEL = 8'h00;
   localparam logic [2:0] WPOM_ACCEPT_FRAMES = 3'h5;
   localparam logic [3:0] WPOM_REI_MAX = 4'h8;
   localparam logic [2:0] WPOM_ERDI_NONE = 3'h1;
   localparam logic [2:0] WPOM_ERDI_PAYLOAD = 3'h2;
   localparam logic [2:0] WPOM_ERDI_CONNECT = 3'h6;
   localparam logic [5:0] WPOM_LAST_ONE = 6'h00;
   localparam logic [5:0] WPOM_LAST_16 = 6'h0F;
   localparam logic [5:0] WPOM_LAST_64 = 6'h3F;
   localparam int WPOM_EVT_W = 5;
   localparam int WPOM_EVT_PARNZ = 0;
   localparam int WPOM_EVT_LREMNZ = 1;
   localparam int WPOM_EVT_PMREMNZ = 2;
   localparam int WPOM_EVT_MISM = 3;
   localparam int WPOM_EVT_UNEQ = 4;
   typedef enum logic [1:0] {
      WPOM_LEN_ONE = 2'h0,
      WPOM_LEN_16 = 2'h1,
      WPOM_LEN_64 = 2'h3
   } wpom_tlen_t;
   typedef struct packed {
      logic [7:0] j1;
      logic [7:0] b3;
      logic [7:0] c2;
      logic [7:0] g1;
   } wpom_poh_t;
endpackage
`default_nettype wire

// *** wpom_top.sv ***
// wan path overhead monitor: trace, parity, label and remote error handling behind apb
`timescale 1ns/10ps
`default_nettype none
module wpom_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_frame_start,
   input wire logic tx_spe_valid,
   input wire logic [7:0] tx_spe_data,
   output wpom_pkg::wpom_poh_t tx_poh,
   input wire logic rx_frame_start,
   input wire logic rx_spe_valid,
   input wire logic [7:0] rx_spe_data,
   input wire wpom_pkg::wpom_poh_t rx_poh,
   input wire logic perf_monitor_tick,
   output logic irq_out_a,
   output logic irq_out_b
);
   function automatic logic [3:0] wpom_ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   function automatic logic [5:0] wpom_last(input logic [1:0] len);
      return (len == wpom_pkg::WPOM_LEN_ONE) ? wpom_pkg::WPOM_LAST_ONE :
             (len == wpom_pkg::WPOM_LEN_64) ? wpom_pkg::WPOM_LAST_64 : wpom_pkg::WPOM_LAST_16;
   endfunction

   function automatic logic [31:0] wpom_sat(input logic [31:0] c, input logic [3:0] inc);
      logic [32:0] s;
      s = {1'b0, c} + {29'h0, inc};
      return s[32] ? 32'hFFFFFFFF : s[31:0];
   endfunction

   // registers
   logic [5:0] ctrl_r;
   logic [7:0] tx_signal_label_r;
   logic [7:0] expected_signal_label_r;
   logic [wpom_pkg::WPOM_EVT_W-1:0] pend_r;
   logic [wpom_pkg::WPOM_EVT_W-1:0] mask_a_r;
   logic [wpom_pkg::WPOM_EVT_W-1:0] mask_b_r;
   logic [31:0] tx_trace_r [wpom_pkg::WPOM_TRACE_WORDS];
   logic [31:0] rx_trace_r [wpom_pkg::WPOM_TRACE_WORDS];
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_a_r;
   logic irq_b_r;
   wpom_pkg::wpom_poh_t tx_poh_r;
   logic [7:0] tx_bip_r;
   logic [5:0] tx_idx_r;
   logic [7:0] rx_bip_r;
   logic rx_seen_r;
   logic [5:0] rx_idx_r;
   logic [15:0] legacy_path_parity_err_count_r;
   logic [31:0] pm_par_acc_r;
   logic [31:0] pm_path_parity_err_count_r;
   logic [15:0] legacy_remote_err_count_r;
   logic [31:0] pm_rem_acc_r;
   logic [31:0] pm_remote_err_count_r;
   logic fifo_vld_r;
   logic [3:0] fifo_cnt_r;
   logic [7:0] c2_cand_r;
   logic [2:0] c2_run_r;
   logic [7:0] c2_acc_r;
   logic c2_acc_vld_r;

   // apb decode
   wire logic apb_take = psel & penable & pready_r;
   wire logic apb_wr = apb_take & pwrite;
   wire logic apb_rd = apb_take & ~pwrite;
   wire logic [5:0] blk = paddr[11:6];
   wire logic [3:0] word = paddr[5:2];
   wire logic hit_ctrl = paddr == wpom_pkg::WPOM_CTRL_OFS;
   wire logic hit_label = paddr == wpom_pkg::WPOM_LABEL_OFS;
   wire logic hit_status = paddr == wpom_pkg::WPOM_STATUS_OFS;
   wire logic hit_pend = paddr == wpom_pkg::WPOM_PEND_OFS;
   wire logic hit_maska = paddr == wpom_pkg::WPOM_MASKA_OFS;
   wire logic hit_maskb = paddr == wpom_pkg::WPOM_MASKB_OFS;
   wire logic hit_lpar = paddr == wpom_pkg::WPOM_LPAR_OFS;
   wire logic hit_pmpar = paddr == wpom_pkg::WPOM_PMPAR_OFS;
   wire logic hit_lrem = paddr == wpom_pkg::WPOM_LREM_OFS;
   wire logic hit_pmrem = paddr == wpom_pkg::WPOM_PMREM_OFS;
   wire logic hit_txt = (blk == wpom_pkg::WPOM_TXTRACE_BLK) & (paddr[1:0] == 2'h0);
   wire logic hit_rxt = (blk == wpom_pkg::WPOM_RXTRACE_BLK) & (paddr[1:0] == 2'h0);
   wire logic hit_any = hit_ctrl | hit_label | hit_status | hit_pend | hit_maska | hit_maskb |
                        hit_lpar | hit_pmpar | hit_lrem | hit_pmrem | hit_txt | hit_rxt;

   // configuration fields
   wire logic [1:0] tx_trace_length_sel = ctrl_r[wpom_pkg::WPOM_CTRL_TXLEN_LSB +: 2];
   wire logic [1:0] rx_trace_length_sel = ctrl_r[wpom_pkg::WPOM_CTRL_RXLEN_LSB +: 2];
   wire logic parity_block_count_mode = ctrl_r[wpom_pkg::WPOM_CTRL_PARBLK_BIT];
   wire logic remote_err_block_count_mode = ctrl_r[wpom_pkg::WPOM_CTRL_REMBLK_BIT];

   // transmit path
   wire logic [7:0] tx_bip_nxt = tx_frame_start ? (tx_spe_valid ? tx_spe_data : 8'h00) :
                                 (tx_spe_valid ? (tx_bip_r ^ tx_spe_data) : tx_bip_r);
   wire logic [5:0] tx_last = wpom_last(tx_trace_length_sel);
   wire logic [5:0] tx_idx_nxt = (tx_idx_r >= tx_last) ? 6'h00 : tx_idx_r + 6'h01;
   wire logic [31:0] tx_word = tx_trace_r[tx_idx_r[5:2]];
   wire logic [7:0] tx_j1 = tx_word[{tx_idx_r[1:0], 3'h0} +: 8];
   wire logic fifo_pop = tx_frame_start & fifo_vld_r;
   wire logic [3:0] tx_rei = fifo_vld_r ? fifo_cnt_r : 4'h0;
   wire logic mism_live = c2_acc_vld_r & (c2_acc_r != wpom_pkg::WPOM_UNEQ_LABEL) &
                          (c2_acc_r != expected_signal_label_r);
   wire logic uneq_live = c2_acc_vld_r & (c2_acc_r == wpom_pkg::WPOM_UNEQ_LABEL);
   // connectivity defect outranks payload defect
   wire logic [2:0] tx_erdi = uneq_live ? wpom_pkg::WPOM_ERDI_CONNECT :
                              mism_live ? wpom_pkg::WPOM_ERDI_PAYLOAD :
                              wpom_pkg::WPOM_ERDI_NONE;

   // receive path
   wire logic [7:0] rx_bip_nxt = rx_frame_start ? (rx_spe_valid ? rx_spe_data : 8'h00) :
                                 (rx_spe_valid ? (rx_bip_r ^ rx_spe_data) : rx_bip_r);
   wire logic rx_check = rx_frame_start & rx_seen_r;
   wire logic [3:0] par_ones = wpom_ones(rx_bip_r ^ rx_poh.b3);
   wire logic par_err = rx_check & (par_ones != 4'h0);
   wire logic [3:0] par_inc = ~rx_check ? 4'h0 :
                              parity_block_count_mode ? {3'h0, par_err} : par_ones;
   wire logic [3:0] rei_raw = rx_poh.g1[7:4];
   wire logic [3:0] rei_val = (rei_raw > wpom_pkg::WPOM_REI_MAX) ? 4'h0 : rei_raw;
   wire logic rem_err = rx_frame_start & (rei_val != 4'h0);
   wire logic [3:0] rem_inc = ~rx_frame_start ? 4'h0 :
                              remote_err_block_count_mode ? {3'h0, rem_err} : rei_val;
   wire logic [31:0] pm_par_sum = wpom_sat(pm_par_acc_r, par_inc);
   wire logic [31:0] pm_rem_sum = wpom_sat(pm_rem_acc_r, rem_inc);
   wire logic [5:0] rx_last = wpom_last(rx_trace_length_sel);
   wire logic [5:0] rx_idx_nxt = (rx_idx_r >= rx_last) ? 6'h00 : rx_idx_r + 6'h01;
   wire logic c2_same = rx_poh.c2 == c2_cand_r;
   wire logic [2:0] c2_run_nxt = ~c2_same ? 3'h1 :
                                 (c2_run_r == wpom_pkg::WPOM_ACCEPT_FRAMES) ? c2_run_r :
                                 c2_run_r + 3'h1;

   // status and events
   wire logic [wpom_pkg::WPOM_EVT_W-1:0] live = {uneq_live, mism_live,
                                                 pm_rem_acc_r != 32'h0,
                                                 legacy_remote_err_count_r != 16'h0,
                                                 pm_par_acc_r != 32'h0};
   wire logic [wpom_pkg::WPOM_EVT_W-1:0] pend_clr = (apb_rd & hit_pend) ? pend_r : '0;
   wire logic [wpom_pkg::WPOM_EVT_W-1:0] pend_nxt = (pend_r & ~pend_clr) | live;
   wire logic [31:0] status_word = {16'h0, c2_acc_r, 3'h0, live};

   wire logic [31:0] rdata = hit_ctrl ? {26'h0, ctrl_r} :
      hit_label ? {16'h0, expected_signal_label_r, tx_signal_label_r} :
      hit_status ? status_word :
      hit_pend ? {27'h0, pend_r} :
      hit_maska ? {27'h0, mask_a_r} :
      hit_maskb ? {27'h0, mask_b_r} :
      hit_lpar ? {16'h0, legacy_path_parity_err_count_r} :
      hit_pmpar ? pm_path_parity_err_count_r :
      hit_lrem ? {16'h0, legacy_remote_err_count_r} :
      hit_pmrem ? pm_remote_err_count_r :
      hit_txt ? tx_trace_r[word] :
      hit_rxt ? rx_trace_r[word] : 32'h0;

   always_ff @(posedge clk) begin
      if (reset) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= psel & penable & ~pready_r;
         pslverr_r <= psel & penable & ~pready_r & ~hit_any;
         prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rdata : 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_r <= wpom_pkg::WPOM_CTRL_RST;
         tx_signal_label_r <= wpom_pkg::WPOM_LABEL_RST;
         expected_signal_label_r <= wpom_pkg::WPOM_LABEL_RST;
         mask_a_r <= '0;
         mask_b_r <= '0;
      end else if (apb_wr) begin
         if (hit_ctrl) ctrl_r <= pwdata[5:0];
         if (hit_label) tx_signal_label_r <= pwdata[7:0];
         if (hit_label) expected_signal_label_r <= pwdata[15:8];
         if (hit_maska) mask_a_r <= pwdata[wpom_pkg::WPOM_EVT_W-1:0];
         if (hit_maskb) mask_b_r <= pwdata[wpom_pkg::WPOM_EVT_W-1:0];
      end
   end

   // trace stores, one word per generate entry
   for (genvar g = 0; g < wpom_pkg::WPOM_TRACE_WORDS; g++) begin : g_trace
      always_ff @(posedge clk) begin
         if (reset) begin
            tx_trace_r[g] <= 32'h0;
         end else if (apb_wr & hit_txt & (word == 4'(g))) begin
            tx_trace_r[g] <= pwdata;
         end
      end
      always_ff @(posedge clk) begin
         if (reset) begin
            rx_trace_r[g] <= 32'h0;
         end else if (rx_frame_start & (rx_idx_r[5:2] == 4'(g))) begin
            rx_trace_r[g][{rx_idx_r[1:0], 3'h0} +: 8] <= rx_poh.j1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_poh_r <= '0;
         tx_bip_r <= 8'h00;
         tx_idx_r <= 6'h00;
      end else begin
         tx_bip_r <= tx_bip_nxt;
         if (tx_frame_start) begin
            tx_poh_r <= '{j1: tx_j1, b3: tx_bip_r, c2: tx_signal_label_r,
                          g1: {tx_rei, tx_erdi, 1'b0}};
            tx_idx_r <= tx_idx_nxt;
         end
      end
   end

   // one-entry fifo: a newer count replaces an unread one
   always_ff @(posedge clk) begin
      if (reset) begin
         fifo_vld_r <= 1'b0;
         fifo_cnt_r <= 4'h0;
      end else if (rx_check) begin
         fifo_vld_r <= 1'b1;
         fifo_cnt_r <= par_ones;
      end else if (fifo_pop) begin
         fifo_vld_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_bip_r <= 8'h00;
         rx_seen_r <= 1'b0;
         rx_idx_r <= 6'h00;
         legacy_path_parity_err_count_r <= 16'h0;
         legacy_remote_err_count_r <= 16'h0;
      end else begin
         rx_bip_r <= rx_bip_nxt;
         if (rx_frame_start) begin
            rx_seen_r <= 1'b1;
            rx_idx_r <= rx_idx_nxt;
         end
         if (par_err) legacy_path_parity_err_count_r <= legacy_path_parity_err_count_r + 16'h1;
         if (rem_err) legacy_remote_err_count_r <= legacy_remote_err_count_r + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pm_par_acc_r <= 32'h0;
         pm_rem_acc_r <= 32'h0;
         pm_path_parity_err_count_r <= 32'h0;
         pm_remote_err_count_r <= 32'h0;
      end else if (perf_monitor_tick) begin
         pm_path_parity_err_count_r <= pm_par_sum;
         pm_remote_err_count_r <= pm_rem_sum;
         pm_par_acc_r <= 32'h0;
         pm_rem_acc_r <= 32'h0;
      end else begin
         pm_par_acc_r <= pm_par_sum;
         pm_rem_acc_r <= pm_rem_sum;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         c2_cand_r <= 8'h00;
         c2_run_r <= 3'h0;
         c2_acc_r <= 8'h00;
         c2_acc_vld_r <= 1'b0;
      end else if (rx_frame_start) begin
         c2_cand_r <= rx_poh.c2;
         c2_run_r <= c2_run_nxt;
         if (c2_run_nxt == wpom_pkg::WPOM_ACCEPT_FRAMES) begin
            c2_acc_r <= rx_poh.c2;
            c2_acc_vld_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pend_r <= '0;
         irq_a_r <= 1'b0;
         irq_b_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         irq_a_r <= |(pend_nxt & mask_a_r);
         irq_b_r <= |(pend_nxt & mask_b_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_poh = tx_poh_r;
   assign irq_out_a = irq_a_r;
   assign irq_out_b = irq_b_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_pend_read;
      apb_rd && hit_pend;
   endsequence
   sequence s_five_zero;
      rx_frame_start && rx_poh.c2 == 8'h00 && c2_cand_r == 8'h00 && c2_run_r == 3'h4;
   endsequence

   property p_tx_b3;
      tx_frame_start |=> tx_poh.b3 == $past(tx_bip_r);
   endproperty
   a_tx_b3: assert property (p_tx_b3) else $error("tx parity octet wrong");
   property p_g1_empty;
      tx_frame_start && !fifo_vld_r |=> tx_poh.g1[7:4] == 4'h0;
   endproperty
   a_g1_empty: assert property (p_g1_empty) else $error("rei not zero on empty");
   property p_g1_count;
      tx_frame_start && fifo_vld_r |=> tx_poh.g1[7:4] == $past(fifo_cnt_r) &&
         fifo_vld_r == $past(rx_check);
   endproperty
   a_g1_count: assert property (p_g1_count) else $error("rei count lost");
   property p_tx_signal_label;
      tx_frame_start |=> tx_poh.c2 == $past(tx_signal_label_r);
   endproperty
   a_tx_signal_label: assert property (p_tx_signal_label) else $error("tx label wrong");
   property p_tick;
      perf_monitor_tick |=> pm_par_acc_r == 32'h0 &&
         pm_path_parity_err_count_r == $past(pm_par_sum);
   endproperty
   a_tick: assert property (p_tick) else $error("tick latch failed");
   property p_uneq;
      s_five_zero |=> uneq_live ##1 pend_r[wpom_pkg::WPOM_EVT_UNEQ];
   endproperty
   a_uneq: assert property (p_uneq) else $error("unequipped missed");
   property p_mism;
      mism_live |=> pend_r[wpom_pkg::WPOM_EVT_MISM] &&
         (!$past(tx_frame_start) || tx_poh_r.g1[3:1] == wpom_pkg::WPOM_ERDI_PAYLOAD);
   endproperty
   a_mism: assert property (p_mism) else $error("mismatch pending missed");
   property p_pend_clear;
      s_pend_read ##0 (live == '0) |=> pend_r == '0 && !irq_out_a;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");
   property p_irq;
      (pend_r & mask_a_r) != '0 && $stable(mask_a_r) |-> irq_out_a;
   endproperty
   a_irq: assert property (p_irq) else $error("irq a not raised");
   property p_rem_wrap;
      rem_err && legacy_remote_err_count_r == 16'hFFFF |=> legacy_remote_err_count_r == 16'h0;
   endproperty
   a_rem_wrap: assert property (p_rem_wrap) else $error("remote count no wrap");
   property p_par_blk;
      parity_block_count_mode && !perf_monitor_tick && pm_par_acc_r < 32'hFFFF0000
         |=> pm_par_acc_r - $past(pm_par_acc_r) <= 32'h1;
   endproperty
   a_par_blk: assert property (p_par_blk) else $error("block mode step above one");
endmodule
`default_nettype wire

// *** wpom_far_end.sv ***
// far-end path terminating equipment model feeding the receive side
`timescale 1ns/10ps
`default_nettype none
module wpom_far_end (
   input wire logic clk,
   output var logic rx_frame_start,
   output var logic rx_spe_valid,
   output var logic [7:0] rx_spe_data,
   output var wpom_pkg::wpom_poh_t rx_poh
);
   logic [7:0] bip_r;
   logic [7:0] pay_r;
   initial begin
      rx_frame_start = 1'b0;
      rx_spe_valid = 1'b0;
      rx_spe_data = 8'h00;
      rx_poh = '0;
      bip_r = 8'h00;
      pay_r = 8'h40;
   end
   // four payload octets; b3 carries the previous frame's parity, spoiled by err
   task automatic send(input logic [7:0] label, input logic [7:0] err, input logic [3:0] rei);
      logic [7:0] acc;
      acc = 8'h00;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rx_frame_start <= (i == 0);
         rx_spe_valid <= 1'b1;
         rx_spe_data <= pay_r;
         rx_poh <= '{8'h5A, bip_r ^ err, label, {rei, 3'h1, 1'b0}};
         acc = acc ^ pay_r;
         pay_r = pay_r + 8'h03;
      end
      bip_r = acc;
      // released lines keep toggling so a stale value never looks valid
      repeat (3) begin
         @(posedge clk);
         rx_frame_start <= 1'b0;
         rx_spe_valid <= 1'b0;
         rx_spe_data <= ~rx_spe_data;
         rx_poh <= ~rx_poh;
      end
   endtask
endmodule
`default_nettype wire

// *** tb_wpom_top.sv ***
// self-checking bench of the wan path overhead monitor
`timescale 1ns/10ps
`default_nettype none
module tb_wpom_top;
   logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic tx_frame_start = 1'b0, tx_spe_valid = 1'b0, perf_monitor_tick = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [7:0] tx_spe_data = 8'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq_out_a, irq_out_b, rx_frame_start, rx_spe_valid, last_err;
   logic [7:0] rx_spe_data, pj;
   wpom_pkg::wpom_poh_t tx_poh, rx_poh;
   int fails = 0, n_compared = 0, cyc = 0;
   wpom_top u_wpom_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_frame_start(tx_frame_start), .tx_spe_valid(tx_spe_valid),
      .tx_spe_data(tx_spe_data), .tx_poh(tx_poh), .rx_frame_start(rx_frame_start),
      .rx_spe_valid(rx_spe_valid), .rx_spe_data(rx_spe_data), .rx_poh(rx_poh),
      .perf_monitor_tick(perf_monitor_tick), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
   wpom_far_end u_wpom_far_end (.clk(clk), .rx_frame_start(rx_frame_start),
      .rx_spe_valid(rx_spe_valid), .rx_spe_data(rx_spe_data), .rx_poh(rx_poh));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task results;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         results();
      end
   end
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
      input string nm);
      apb(1'b0, a, 32'h00000000);
      check(nm, rd & m, e);
   endtask
   function automatic logic [11:0] tra(input logic [5:0] b, input int w);
      return {b, w[3:0], 2'b00};
   endfunction
   function automatic logic [7:0] bip4(input logic [7:0] p);
      return p ^ (p + 8'h01) ^ (p + 8'h02) ^ (p + 8'h03);
   endfunction
   // one transmit frame of four payload octets starting at base
   task automatic txf(input logic [7:0] base);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         tx_frame_start <= (i == 0);
         tx_spe_valid <= 1'b1;
         tx_spe_data <= base + 8'(i);
      end
      @(posedge clk);
      tx_frame_start <= 1'b0;
      tx_spe_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic tick;
      @(posedge clk);
      perf_monitor_tick <= 1'b1;
      @(posedge clk);
      perf_monitor_tick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rchk(wpom_pkg::WPOM_CTRL_OFS, '1, 32'h00000005, "ctrl");
      rchk(wpom_pkg::WPOM_LABEL_OFS, '1, 32'h00001A1A, "label");
      rchk(wpom_pkg::WPOM_PEND_OFS, '1, 32'h00000000, "pend");
      rchk(tra(wpom_pkg::WPOM_TXTRACE_BLK, 0), '1, 32'h00000000, "tx trace");
      rchk(12'h028, '1, 32'h00000000, "unmapped data");
      check("unmapped err", {31'h0, last_err}, 32'h00000001);
      $display("test reset done");
      for (int w = 0; w < 4; w++) begin
         wr_trace(w);
      end
      for (int f = 0; f < 17; f++) begin
         txf(8'(f * 8));
         check("tx g1", {24'h0, tx_poh.g1}, 32'h00000002);
         if (f > 0) begin
            check("tx j1", {24'h0, tx_poh.j1}, {24'h0, 4'h1, pj[3:0] + 4'h1});
            check("tx b3", {24'h0, tx_poh.b3}, {24'h0, bip4(8'(f * 8 - 8))});
         end
         pj = tx_poh.j1;
      end
      check("tx_signal_label", {24'h0, tx_poh.c2}, 32'h0000001A);
      apb(1'b1, wpom_pkg::WPOM_LABEL_OFS, 32'h00001A33);
      apb(1'b1, wpom_pkg::WPOM_CTRL_OFS, 32'h00000004);
      repeat (2) txf(8'h00);
      check("tx_signal_label prog", {24'h0, tx_poh.c2}, 32'h00000033);
      check("tx j1 one", {24'h0, tx_poh.j1}, 32'h00000010);
      apb(1'b1, wpom_pkg::WPOM_CTRL_OFS, 32'h00000005);
      $display("test transmit done");
      repeat (6) u_wpom_far_end.send(8'h1A, 8'h00, 4'h0);
      rchk(wpom_pkg::WPOM_STATUS_OFS, 32'hFF1F, 32'h1A00, "status");
      u_wpom_far_end.send(8'h1A, 8'h03, 4'h0);
      txf(8'h00);
      check("rei out", {28'h0, tx_poh.g1[7:4]}, 32'h00000002);
      u_wpom_far_end.send(8'h1A, 8'h01, 4'h0);
      u_wpom_far_end.send(8'h1A, 8'h07, 4'h0);
      txf(8'h00);
      check("rei newer", {28'h0, tx_poh.g1[7:4]}, 32'h00000003);
      txf(8'h00);
      check("rei empty", {28'h0, tx_poh.g1[7:4]}, 32'h00000000);
      rchk(wpom_pkg::WPOM_LPAR_OFS, '1, 32'h00000003, "legacy parity");
      rchk(wpom_pkg::WPOM_PEND_OFS, 32'h1, 32'h1, "parity pend");
      tick;
      rchk(wpom_pkg::WPOM_PMPAR_OFS, '1, 32'h00000006, "pm parity");
      apb(1'b0, wpom_pkg::WPOM_PEND_OFS, 32'h00000000);
      rchk(wpom_pkg::WPOM_PEND_OFS, 32'h1, 32'h0, "parity pend clear");
      apb(1'b1, wpom_pkg::WPOM_CTRL_OFS, 32'h00000015);
      u_wpom_far_end.send(8'h1A, 8'hFF, 4'h0);
      tick;
      rchk(wpom_pkg::WPOM_PMPAR_OFS, '1, 32'h00000001, "pm parity block");
      rchk(wpom_pkg::WPOM_LPAR_OFS, '1, 32'h00000004, "legacy parity");
      u_wpom_far_end.send(8'h1A, 8'h00, 4'h3);
      rchk(wpom_pkg::WPOM_PEND_OFS, 32'h6, 32'h6, "remote pend");
      tick;
      rchk(wpom_pkg::WPOM_PMREM_OFS, '1, 32'h00000003, "pm remote");
      apb(1'b1, wpom_pkg::WPOM_CTRL_OFS, 32'h00000035);
      u_wpom_far_end.send(8'h1A, 8'h00, 4'h3);
      tick;
      rchk(wpom_pkg::WPOM_PMREM_OFS, '1, 32'h00000001, "pm remote block");
      $display("test counters done");
      repeat (5) u_wpom_far_end.send(8'h00, 8'h00, 4'h0);
      rchk(wpom_pkg::WPOM_STATUS_OFS, 32'hFF18, 32'h0010, "unequipped");
      rchk(wpom_pkg::WPOM_PEND_OFS, 32'h10, 32'h10, "unequipped pend");
      txf(8'h00);
      check("erdi uneq", {28'h0, tx_poh.g1[3:0]}, 32'h0000000C);
      repeat (5) u_wpom_far_end.send(8'h22, 8'h00, 4'h0);
      rchk(wpom_pkg::WPOM_STATUS_OFS, 32'hFF18, 32'h2208, "mismatch");
      txf(8'h00);
      check("erdi mism", {28'h0, tx_poh.g1[3:0]}, 32'h00000004);
      apb(1'b1, wpom_pkg::WPOM_MASKA_OFS, 32'h00000008);
      repeat (3) @(posedge clk);
      check("irq a", {30'h0, irq_out_b, irq_out_a}, 32'h00000001);
      apb(1'b1, wpom_pkg::WPOM_MASKA_OFS, 32'h00000000);
      apb(1'b1, wpom_pkg::WPOM_MASKB_OFS, 32'h00000008);
      repeat (3) @(posedge clk);
      check("irq b", {30'h0, irq_out_b, irq_out_a}, 32'h00000002);
      for (int w = 0; w < 4; w++) begin
         rchk(tra(wpom_pkg::WPOM_RXTRACE_BLK, w), '1, 32'h5A5A5A5A, "rx trace");
      end
      rchk(tra(wpom_pkg::WPOM_RXTRACE_BLK, 4), '1, 32'h00000000, "rx trace ext");
      $display("test label and trace done");
      results();
   end
   // octets 0x10 upward, octet k in byte k%4 of word k/4
   task automatic wr_trace(input int w);
      apb(1'b1, tra(wpom_pkg::WPOM_TXTRACE_BLK, w), 32'h13121110 + {4{w[5:0], 2'b00}});
   endtask
endmodule
`default_nettype wire
